// File: hopp_top.sv
// home offset storage and position preset for a servo drive axis
`include "hopp_defines.svh"

module hopp_top (
    input  wire logic           CLK,                       // control clock
    input  wire logic           RST_N,                     // sync reset
    input  wire logic           OBJ_WR,                    // object write
    input  wire logic           OBJ_RD,                    // object read
    input  wire logic [15:0]    OBJ_INDEX,                 // object index
    input  wire logic [31:0]    OBJ_WDATA,                 // write data
    input  wire logic           EV_INIT_PREOP,             // Init->PreOP
    input  wire logic           EV_HOME_DONE,              // homing done
    input  wire logic           EV_MTURN_CLEAR,            // multi-turn clr
    input  wire logic           EV_TOOL_DONE,              // tool op done
    input  wire logic           EV_PIN_ASSIGN,             // pin assign set
    input  wire logic           EV_COMMAND_ERROR,          // command error
    input  wire logic [31:0]    HOME_INDEX_POS,            // index pulse pos
    input  wire logic [31:0]    ENC_POS,                   // encoder count
    input  wire logic [23:0]    SCALE_LOW,                 // scale low word
    input  wire logic [23:0]    SCALE_HIGH,                // scale high word
    input  wire logic           ABS_SYSTEM,                // absolute system
    input  wire logic           FULL_CLOSED,               // full-closed ctl
    input  wire logic [7:0]     DIRECTION_POLARITY,        // polarity code
    input  wire logic [31:0]    GEAR_NUM,                  // gear numerator
    input  wire logic [31:0]    GEAR_DEN,                  // gear denominator
    input  wire logic [31:0]    DEMAND_DELTA,              // demand step
    input  wire logic           ERR_CLEAR,                 // clear overflow
    output logic [31:0]         OBJ_RDATA,                 // read data
    output logic                OBJ_RVALID,                // read answer
    output logic [31:0]         INTERNAL_ACTUAL_POSITION,  // internal actual
    output logic [31:0]         INTERNAL_DEMAND_POSITION,  // internal demand
    output logic [31:0]         USER_ACTUAL_POSITION,      // user actual
    output logic [31:0]         USER_DEMAND_POSITION,      // user demand
    output logic                COUNTER_OVERFLOW_ERROR,    // sticky overflow
    output logic                PRESET_DONE                // preset pulse
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    hopp_pkg::hopp_state_t  state_q, state_d;        // preset sequencer
    logic [31:0]            shadow_q, shadow_d;      // written offset
    logic [31:0]            offset_q, offset_d;      // applied offset
    logic [31:0]            zero_ref_q, zero_ref_d;  // coordinate origin
    logic [31:0]            int_act_q, int_act_d;    // internal actual
    logic [31:0]            int_dem_q, int_dem_d;    // internal demand
    logic [31:0]            usr_act_q, usr_act_d;    // user actual
    logic [31:0]            usr_dem_q, usr_dem_d;    // user demand
    logic                   ovf_q, ovf_d;            // overflow flag
    logic [31:0]            rdata_q, rdata_d;        // read data
    logic                   rvalid_q, rvalid_d;      // read answer
    logic                   done_q, done_d;          // preset pulse

    logic                   hit;          // object index matches
    logic                   powerup;      // power-up preset cycle
    logic                   home_ev;      // preset by home detection
    logic                   preset_any;   // any preset this cycle
    logic                   scale_mode;   // absolute full-closed
    logic                   neg;          // reversed polarity
    logic [31:0]            raw_pos;      // uncorrected position
    hopp_pkg::hopp_pos_t    scale_int;    // scale internal value
    hopp_pkg::hopp_wide_t   scale_usr;    // scale user-path value
    hopp_pkg::hopp_wide_t   act_in;       // gear input, actual path
    hopp_pkg::hopp_wide_t   dem_in;       // gear input, demand path
    hopp_pkg::hopp_pos_t    act_g;        // geared actual
    hopp_pkg::hopp_pos_t    dem_g;        // geared demand
    logic                   act_ovf;      // overflow, actual path

    // ****************************************************************
    // submodules
    // ****************************************************************
    // scale words to internal and user-path values
    hopp_scale u_scale (
        .scale_low  (SCALE_LOW),
        .scale_high (SCALE_HIGH),
        .int_sum    (scale_int),
        .user_val   (scale_usr)
    );

    // actual position gear and sign
    hopp_gear u_gear_act (
        .pos_in   (act_in),
        .gear_num (GEAR_NUM),
        .gear_den (GEAR_DEN),
        .negate   (neg),
        .pos_out  (act_g),
        .overflow (act_ovf)
    );

    // demand position gear and sign; its overflow is not a scale fault
    hopp_gear u_gear_dem (
        .pos_in   (dem_in),
        .gear_num (GEAR_NUM),
        .gear_den (GEAR_DEN),
        .negate   (neg),
        .pos_out  (dem_g),
        .overflow ()
    );

    // ****************************************************************
    // event decode
    // ****************************************************************
    // power-up preset happens once, in the first cycle after reset
    always_comb
    begin
        hit        = (OBJ_INDEX == `HOPP_IDX_HOME_OFFSET);
        powerup    = (state_q == hopp_pkg::HOPP_ST_POWERUP);
        home_ev    = !powerup && EV_HOME_DONE;
        preset_any = powerup || EV_INIT_PREOP || EV_HOME_DONE
                   || EV_MTURN_CLEAR || EV_TOOL_DONE
                   || EV_PIN_ASSIGN || EV_COMMAND_ERROR;
        scale_mode = ABS_SYSTEM && FULL_CLOSED;
        neg        = (DIRECTION_POLARITY == `HOPP_POL_REVERSED);
    end

    // ****************************************************************
    // object access and offset transfer
    // ****************************************************************
    // writes land in the shadow any time; the applied copy only moves
    // on a preset, so intermediate writes never disturb positions
    always_comb
    begin
        state_d  = hopp_pkg::HOPP_ST_RUN;
        shadow_d = (OBJ_WR && hit) ? OBJ_WDATA : shadow_q;
        offset_d = preset_any ? shadow_d : offset_q;
        rvalid_d = OBJ_RD;
        rdata_d  = (OBJ_RD && hit) ? shadow_q : 32'h0000_0000;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            state_q  <= hopp_pkg::HOPP_ST_POWERUP;
            shadow_q <= `HOPP_HOME_OFFSET_RST;
            offset_q <= `HOPP_HOME_OFFSET_RST;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end
        else
        begin
            state_q  <= state_d;
            shadow_q <= shadow_d;
            offset_q <= offset_d;
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
        end
    end

    // ****************************************************************
    // position computation and preset
    // ****************************************************************
    always_comb
    begin
        // origin: power-up spot (incremental), index pulse after homing
        zero_ref_d = zero_ref_q;
        if (powerup)
        begin
            zero_ref_d = ABS_SYSTEM ? 32'h0000_0000 : ENC_POS;
        end
        else if (home_ev)
        begin
            zero_ref_d = HOME_INDEX_POS;
        end
        // absolute full-closed reads the external scale, else the encoder
        raw_pos   = scale_mode ? scale_int : ENC_POS;
        int_act_d = raw_pos - zero_ref_d;
        act_in    = scale_mode
                  ? scale_usr - {{16{zero_ref_d[31]}}, zero_ref_d}
                  : {{16{int_act_d[31]}}, int_act_d};
        // demand follows the profile, presets overwrite it
        if (home_ev)
        begin
            int_act_d = 32'h0000_0000;
            int_dem_d = 32'h0000_0000;
        end
        else if (preset_any)
        begin
            int_dem_d = int_act_d;
        end
        else
        begin
            int_dem_d = int_dem_q + DEMAND_DELTA;
        end
        dem_in = {{16{int_dem_d[31]}}, int_dem_d};
        // user scale: geared and signed, then offset added
        if (home_ev)
        begin
            usr_act_d = offset_d;
            usr_dem_d = offset_d;
        end
        else
        begin
            usr_act_d = act_g + offset_d;
            usr_dem_d = dem_g + offset_d;
        end
        // sticky error; a new overflow wins over a clear
        ovf_d  = (scale_mode && act_ovf)
               || (ovf_q && !ERR_CLEAR);
        done_d = preset_any;
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            zero_ref_q <= 32'h0000_0000;
            int_act_q  <= 32'h0000_0000;
            int_dem_q  <= 32'h0000_0000;
            usr_act_q  <= 32'h0000_0000;
            usr_dem_q  <= 32'h0000_0000;
            ovf_q      <= 1'b0;
            done_q     <= 1'b0;
        end
        else
        begin
            zero_ref_q <= zero_ref_d;
            int_act_q  <= int_act_d;
            int_dem_q  <= int_dem_d;
            usr_act_q  <= usr_act_d;
            usr_dem_q  <= usr_dem_d;
            ovf_q      <= ovf_d;
            done_q     <= done_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign OBJ_RDATA                = rdata_q;
    assign OBJ_RVALID               = rvalid_q;
    assign INTERNAL_ACTUAL_POSITION = int_act_q;
    assign INTERNAL_DEMAND_POSITION = int_dem_q;
    assign USER_ACTUAL_POSITION     = usr_act_q;
    assign USER_DEMAND_POSITION     = usr_dem_q;
    assign COUNTER_OVERFLOW_ERROR   = ovf_q;
    assign PRESET_DONE              = done_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // plain 1:1 gear, encoder path, either polarity
    logic unity;
    assign unity = (GEAR_NUM == 32'h0000_0001)
                && (GEAR_DEN == 32'h0000_0001) && !scale_mode;

    home_zero_a: assert property (home_ev |=>
        INTERNAL_ACTUAL_POSITION == 32'h0 && INTERNAL_DEMAND_POSITION == 32'h0)
        else $error("home preset did not zero internal positions");
    home_user_a: assert property (home_ev |=>
        USER_ACTUAL_POSITION == offset_q && USER_DEMAND_POSITION == offset_q)
        else $error("home preset user positions differ from offset");
    preset_copy_a: assert property (preset_any && !home_ev |=>
        INTERNAL_DEMAND_POSITION == INTERNAL_ACTUAL_POSITION)
        else $error("preset did not copy actual into demand");
    offset_hold_a: assert property (!preset_any |=> $stable(offset_q))
        else $error("applied offset moved without a preset event");
    offset_take_a: assert property (OBJ_WR && hit ##1 preset_any
        && !(OBJ_WR && hit) |=> offset_q == $past(OBJ_WDATA, 2))
        else $error("written offset not applied at preset");
    user_unity_a: assert property (unity && !neg && !home_ev |=>
        USER_ACTUAL_POSITION == INTERNAL_ACTUAL_POSITION + offset_q)
        else $error("user actual is not internal plus offset");
    user_neg_a: assert property (unity && neg && !home_ev |=>
        USER_ACTUAL_POSITION == offset_q - INTERNAL_ACTUAL_POSITION)
        else $error("reversed polarity not negated");
    powerup_zero_a: assert property (powerup && !ABS_SYSTEM |=>
        INTERNAL_ACTUAL_POSITION == 32'h0)
        else $error("incremental power-up origin not zero");
    scale_sum_a: assert property (scale_mode && !home_ev &&
        zero_ref_d == 32'h0 |=> INTERNAL_ACTUAL_POSITION ==
        {$past(SCALE_HIGH[7:0]), $past(SCALE_LOW)})
        else $error("scale internal sum wrong");
    ovf_set_a: assert property (scale_mode && act_ovf |=>
        COUNTER_OVERFLOW_ERROR)
        else $error("overflow not raised");
    // a clear in the very cycle after the overflow is legal, so the hold
    // is checked cycle by cycle rather than as a fixed two-cycle run
    ovf_hold_a: assert property (COUNTER_OVERFLOW_ERROR && !ERR_CLEAR
        |=> COUNTER_OVERFLOW_ERROR)
        else $error("overflow flag dropped without a clear");
    ovf_clear_a: assert property (ERR_CLEAR && !(scale_mode && act_ovf)
        |=> !COUNTER_OVERFLOW_ERROR)
        else $error("overflow flag not cleared");
    obj_read_a: assert property (OBJ_RD && hit |=>
        OBJ_RVALID && OBJ_RDATA == $past(shadow_q))
        else $error("home offset read returned wrong data");
    // the preset pulse and the read answer are high only in the cycle after a preset or a read
    done_set_a: assert property (preset_any |=> PRESET_DONE)
        else $error("preset pulse missing");
    done_pulse_a: assert property (!preset_any |=> !PRESET_DONE)
        else $error("preset pulse without a preset event");
    read_pulse_a: assert property (!OBJ_RD |=> !OBJ_RVALID)
        else $error("read answer without a read");

    home_c: cover property (OBJ_WR && hit ##[1:20] home_ev);
    preset_c: cover property (EV_INIT_PREOP && !EV_HOME_DONE);
    ovf_c: cover property (scale_mode && act_ovf);
    read_c: cover property (OBJ_RD && hit ##1 OBJ_RVALID);

endmodule : hopp_top

// File: hopp_defines.svh
// constants for the home offset position preset block
// ****************************************************************
// ****************************************************************
`ifndef HOPP_DEFINES_SVH
`define HOPP_DEFINES_SVH

// object index of the home offset
`define HOPP_IDX_HOME_OFFSET    16'h607C
// home offset value after reset
`define HOPP_HOME_OFFSET_RST    32'h0000_0000
// polarity code for reversed direction (224)
`define HOPP_POL_REVERSED       8'hE0
// significant bits of the high scale word
`define HOPP_H_INT_BITS         8
`define HOPP_H_USER_BITS        21
// largest legal intermediate and result widths
`define HOPP_PROD_BITS          64
`define HOPP_POS_BITS           32

`endif

// File: hopp_pkg.sv
// types shared by the home offset position preset block
package hopp_pkg;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef logic signed [31:0] hopp_pos_t;   // 32-bit position object
    typedef logic signed [47:0] hopp_wide_t;  // scale-width position

    // preset sequencer
    typedef enum logic [0:0] {
        HOPP_ST_POWERUP,  // first cycle after reset: power-up preset
        HOPP_ST_RUN       // normal tracking
    } hopp_state_t;

endpackage : hopp_pkg

// File: hopp_scale.sv
// absolute external scale word assembly for full-closed control
`include "hopp_defines.svh"

module hopp_scale (
    input  wire logic [23:0]        scale_low,   // lower 24-bit word
    input  wire logic [23:0]        scale_high,  // upper 24-bit word
    output hopp_pkg::hopp_pos_t     int_sum,     // internal-scale value
    output hopp_pkg::hopp_wide_t    user_val     // value fed to the gear
);

    // ****************************************************************
    // word assembly
    // ****************************************************************
    // internal value: only the low 8 high bits survive in 32 bits
    assign int_sum  = {scale_high[`HOPP_H_INT_BITS-1:0], scale_low};

    // user value: 21 high bits plus 24 low bits, sign extended to 48
    assign user_val = {{3{scale_high[`HOPP_H_USER_BITS-1]}},
                       scale_high[`HOPP_H_USER_BITS-1:0], scale_low};

endmodule : hopp_scale

// File: hopp_gear.sv
// electronic gear reverse conversion with polarity and overflow check
`include "hopp_defines.svh"

module hopp_gear (
    input  hopp_pkg::hopp_wide_t    pos_in,    // position to convert
    input  wire logic [31:0]        gear_num,  // conversion numerator
    input  wire logic [31:0]        gear_den,  // conversion denominator
    input  wire logic               negate,    // reversed polarity
    output hopp_pkg::hopp_pos_t     pos_out,   // converted, wrapped to 32
    output logic                    overflow   // result or product too wide
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // true when v is representable in w signed bits
    function automatic logic fits(input logic signed [80:0] v,
                                  input int unsigned w);
        logic ok;
        ok = 1'b1;
        for (int unsigned i = 0; i < 81; i++)
        begin
            if (i >= w - 1 && v[i] != v[w-1])
            begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : fits

    logic signed [80:0] prod;  // full product, never truncated
    logic signed [80:0] quot;  // product over denominator
    logic signed [80:0] sres;  // signed result before wrapping
    logic [31:0]        den;   // zero denominator treated as one

    // ****************************************************************
    // conversion
    // ****************************************************************
    // a combinational divider is large; the control cycle is slow
    // enough that the area was traded for zero latency
    always_comb
    begin
        den      = (gear_den == 32'h0000_0000) ? 32'h0000_0001 : gear_den;
        prod     = pos_in * $signed({1'b0, gear_num});
        quot     = prod / $signed({49'h0, den});
        sres     = negate ? -quot : quot;
        pos_out  = sres[31:0];
        overflow = !fits(prod, `HOPP_PROD_BITS)
                 || !fits(quot, `HOPP_POS_BITS);
    end

endmodule : hopp_gear

// File: hopp_master_model.sv
// fieldbus master model: object writes, reads and position re-reads
module hopp_master_model (
    input  wire logic        clk,          // control clock
    input  wire logic [31:0] obj_rdata,    // read answer data
    input  wire logic        obj_rvalid,   // read answer strobe
    input  wire logic        preset_done,  // device preset pulse
    input  wire logic [31:0] user_actual,  // user-scale actual position
    output logic             obj_wr,       // write strobe
    output logic             obj_rd,       // read strobe
    output logic [15:0]      obj_index,    // object index
    output logic [31:0]      obj_wdata     // write data
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // master state
    // ****************************************************************
    logic [31:0] reacq_pos;  // position taken again after a preset

    // idle bus at time zero
    initial
    begin
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        obj_index = 16'h0000;
        obj_wdata = 32'h0000_0000;
    end

    // old captures are stale after homing, so refresh on every preset
    always_ff @(posedge clk)
    begin
        if (preset_done === 1'b1)
            reacq_pos <= user_actual;
    end

    // one-cycle write; released lines show the inverse, not the old value
    task automatic write_obj(input logic [15:0] idx, input logic [31:0] d);
        @(posedge clk);
        obj_wr <= 1'b1;
        obj_index <= idx;
        obj_wdata <= d;
        @(posedge clk);
        obj_wr <= 1'b0;
        obj_index <= ~idx;
        obj_wdata <= ~d;
    endtask : write_obj

    // one-cycle read, answer awaited for a bounded number of edges
    task automatic read_obj(input logic [15:0] idx, output logic [31:0] d,
                            output bit ok);
        int n;
        ok = 1'b0;
        d = 32'h0000_0000;
        @(posedge clk);
        obj_rd <= 1'b1;
        obj_index <= idx;
        @(posedge clk);
        obj_rd <= 1'b0;
        obj_index <= ~idx;
        // the answer stands from the taking edge up to the next one
        for (n = 0; n < 4 && !ok; n++)
        begin
            #1;
            if (obj_rvalid === 1'b1)
            begin
                ok = 1'b1;
                d = obj_rdata;
            end
            else
            begin
                @(posedge clk);
            end
        end
    endtask : read_obj
endmodule : hopp_master_model

// File: tb_hopp_top.sv
// self-checking bench for the home offset preset block
`include "hopp_defines.svh"
module tb_hopp_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // stimulus and observation
    // ****************************************************************
    logic        CLK, RST_N, ERR_CLEAR, ABS_SYSTEM, FULL_CLOSED;
    logic [5:0]  ev;  // home, cmd error, pin, tool, multi-turn, init
    logic [31:0] HOME_INDEX_POS, ENC_POS, GEAR_NUM, GEAR_DEN, DEMAND_DELTA;
    logic [23:0] SCALE_LOW, SCALE_HIGH;
    logic [7:0]  DIRECTION_POLARITY;
    logic        wr, rd, rvalid, ovf, pdone;
    logic [15:0] idx;
    logic [31:0] wdata, rdata, ia, id_pos, ua, ud, rd_val;
    bit          ok;
    int          err_count, cmp_count, i;

    hopp_top u_dut (.CLK(CLK), .RST_N(RST_N), .OBJ_WR(wr), .OBJ_RD(rd),
        .OBJ_INDEX(idx), .OBJ_WDATA(wdata), .EV_INIT_PREOP(ev[0]),
        .EV_MTURN_CLEAR(ev[1]), .EV_TOOL_DONE(ev[2]), .EV_PIN_ASSIGN(ev[3]),
        .EV_COMMAND_ERROR(ev[4]), .EV_HOME_DONE(ev[5]),
        .HOME_INDEX_POS(HOME_INDEX_POS), .ENC_POS(ENC_POS),
        .SCALE_LOW(SCALE_LOW), .SCALE_HIGH(SCALE_HIGH),
        .ABS_SYSTEM(ABS_SYSTEM), .FULL_CLOSED(FULL_CLOSED),
        .DIRECTION_POLARITY(DIRECTION_POLARITY), .GEAR_NUM(GEAR_NUM),
        .GEAR_DEN(GEAR_DEN), .DEMAND_DELTA(DEMAND_DELTA),
        .ERR_CLEAR(ERR_CLEAR), .OBJ_RDATA(rdata), .OBJ_RVALID(rvalid),
        .INTERNAL_ACTUAL_POSITION(ia), .INTERNAL_DEMAND_POSITION(id_pos),
        .USER_ACTUAL_POSITION(ua), .USER_DEMAND_POSITION(ud),
        .COUNTER_OVERFLOW_ERROR(ovf), .PRESET_DONE(pdone));

    hopp_master_model u_mst (.clk(CLK), .obj_rdata(rdata),
        .obj_rvalid(rvalid), .preset_done(pdone), .user_actual(ua),
        .obj_wr(wr), .obj_rd(rd), .obj_index(idx), .obj_wdata(wdata));

    // ****************************************************************
    // helper tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    // outputs follow inputs of the previous edge: two edges to settle
    task automatic settle();
        @(posedge CLK);
        @(posedge CLK);
        #1;
    endtask : settle

    // one-cycle event pulse from the current edge, result at the next;
    // callers are always at an edge, so a write just before is adjacent
    task automatic pulse(input logic [5:0] m);
        ev <= m;
        @(posedge CLK);
        ev <= 6'h00;
        #1;
        chk("preset done", {31'h0000_0000, pdone}, 32'h0000_0001);
    endtask : pulse

    // a missing answer is fatal to the run, so close it at once
    task automatic rd_obj(input logic [15:0] x);
        u_mst.read_obj(x, rd_val, ok);
        if (!ok)
        begin
            err_count++;
            end_sim();
        end
    endtask : rd_obj

    // one full-closed scale case; user value unchecked when the overflow flag is expected set
    task automatic fc(input logic [23:0] h, l, input logic [7:0] pol,
                      input logic [31:0] num, den, eia, eua, input logic eo);
        @(posedge CLK);
        SCALE_HIGH <= h;
        SCALE_LOW <= l;
        DIRECTION_POLARITY <= pol;
        GEAR_NUM <= num;
        GEAR_DEN <= den;
        settle();
        chk("internal actual", ia, eia);
        if (eo === 1'b0)
            chk("user actual", ua, eua);
        chk("overflow", {31'h0000_0000, ovf}, {31'h0000_0000, eo});
    endtask : fc

    // ****************************************************************
    // clock and main sequence
    // ****************************************************************
    initial
    begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    initial
    begin
        {RST_N, ERR_CLEAR, ABS_SYSTEM, FULL_CLOSED} = 4'h0;
        ev = 6'h00;
        {HOME_INDEX_POS, DEMAND_DELTA} = 64'h0000_0000_0000_0000;
        ENC_POS = 32'h0000_1000;
        {GEAR_NUM, GEAR_DEN} = 64'h0000_0001_0000_0001;
        {SCALE_LOW, SCALE_HIGH} = 48'h0000_0000_0000;
        DIRECTION_POLARITY = 8'h00;
        repeat (8) @(posedge CLK);
        RST_N <= 1'b1;
        #1;
        chk("reset user actual", ua, 32'h0000_0000);
        rd_obj(`HOPP_IDX_HOME_OFFSET);
        chk("offset reset", rd_val, `HOPP_HOME_OFFSET_RST);
        chk("power-up zero", ia, 32'h0000_0000);
        @(posedge CLK);
        ENC_POS <= 32'h0000_1025;
        settle();
        chk("moved actual", ia, 32'h0000_0025);
        u_mst.write_obj(`HOPP_IDX_HOME_OFFSET, 32'h0000_0100);
        settle();
        chk("offset not applied", ua, 32'h0000_0025);
        rd_obj(`HOPP_IDX_HOME_OFFSET);
        chk("offset read", rd_val, 32'h0000_0100);
        rd_obj(16'h6064);
        chk("unmapped read", rd_val, 32'h0000_0000);
        @(posedge CLK);
        DEMAND_DELTA <= 32'h0000_0005;
        // every non-home event, demand drifting away between them
        for (i = 0; i < 5; i++)
        begin
            u_mst.write_obj(`HOPP_IDX_HOME_OFFSET, 32'h0000_0200 + i);
            pulse(6'h01 << i);
            chk("demand copy", id_pos, 32'h0000_0025);
            chk("user actual", ua, 32'h0000_0225 + i);
            chk("user demand", ud, 32'h0000_0225 + i);
        end
        @(posedge CLK);
        DEMAND_DELTA <= 32'h0000_0000;
        HOME_INDEX_POS <= 32'h0000_1010;
        u_mst.write_obj(`HOPP_IDX_HOME_OFFSET, 32'h0000_0700);
        pulse(6'h21);
        chk("home actual", ia, 32'h0000_0000);
        chk("home demand", id_pos, 32'h0000_0000);
        chk("home user actual", ua, 32'h0000_0700);
        chk("home user demand", ud, 32'h0000_0700);
        @(posedge CLK);
        #1;
        chk("index relative", ia, 32'h0000_0015);
        chk("index user", ua, 32'h0000_0715);
        chk("re-read position", u_mst.reacq_pos, 32'h0000_0700);
        @(posedge CLK);
        DIRECTION_POLARITY <= `HOPP_POL_REVERSED;
        settle();
        chk("reversed user", ua, 32'h0000_06EB);
        @(posedge CLK);
        ABS_SYSTEM <= 1'b1;
        FULL_CLOSED <= 1'b1;
        HOME_INDEX_POS <= 32'h0000_0000;
        pulse(6'h20);
        fc(24'hE0_0056, 24'h00_0010, 8'h00, 32'h1, 32'h1,
           32'h5600_0010, 32'h5600_0710, 1'b0);
        fc(24'hE0_0056, 24'h00_0010, `HOPP_POL_REVERSED, 32'h1, 32'h1,
           32'h5600_0010, 32'hAA00_06F0, 1'b0);
        fc(24'h00_0000, 24'h00_0010, 8'h00, 32'h3, 32'h2,
           32'h0000_0010, 32'h0000_0718, 1'b0);
        fc(24'h00_0100, 24'h00_0010, 8'h00, 32'h1, 32'h1,
           32'h0000_0010, 32'h0000_0000, 1'b1);
        fc(24'h00_0000, 24'h00_0010, 8'h00, 32'h1, 32'h1,
           32'h0000_0010, 32'h0000_0000, 1'b1);
        // clear and a new overflow in one cycle: the set must win
        @(posedge CLK);
        SCALE_HIGH <= 24'h00_0100;
        ERR_CLEAR <= 1'b1;
        @(posedge CLK);
        ERR_CLEAR <= 1'b0;
        #1;
        chk("set beats clear", {31'h0000_0000, ovf}, 32'h0000_0001);
        @(posedge CLK);
        SCALE_HIGH <= 24'h00_0000;
        ERR_CLEAR <= 1'b1;
        @(posedge CLK);
        ERR_CLEAR <= 1'b0;
        @(posedge CLK);
        #1;
        chk("overflow cleared", {31'h0000_0000, ovf}, 32'h0000_0000);
        end_sim();
    end
endmodule : tb_hopp_top
